// ===== rtl/srb_top.sv
// Reset merge, wake-up timing, brownout, protection and vector map control.
// Contract
// (R1) Pin, watchdog, power-on and brownout causes merge into one reset.
// (R2) Any reset starts the oscillator wake-up timer once supply is usable.
// (R3) Reset holds until pin free, oscillator runs, count ends, flash ready.
// (R4) On release registers are defined and vectors map to boot block.
// (R5) Brownout warning comparator raises an interrupt request.
// (R6) Brownout level is always readable in a status register.
// (R7) Brownout reset comparator asserts reset and blocks flash writes.
// (R8) Brownout reset holds as supply falls; power-on reset takes over.
// (R9) Protection level comes from a pattern read from a flash word.
// (R10) Level one blocks debug; boot loader may not touch sector zero.
// (R11) Level two blocks debug; boot loader allows only full erase.
// (R12) Level three blocks debug, boot loader and the override pin.
// (R13) In-application flash calls stay available at every level.
// (R14) Software selects boot ROM, SRAM or external memory vectors.
// (R15) Enabled external interrupts wake the processor from power-down.
// (R16) Wake resumes after 4 oscillator cycles, or 4096 on main oscillator.
// (R17) Reset causes assert at once and release through two flip-flops.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "srb_consts.svh"
module srb_top #(
  parameter int RST_CNT = `SRB_RST_CNT,
  parameter int NIRQ = `SRB_NIRQ
) (
  input wire logic i_clk, // 40 MHz internal oscillator clock.
  input wire logic i_rst, // Block reset, active high.
  input wire logic i_rst_pin_n, // External reset pin, active low.
  input wire logic i_wdt_timeout, // Watchdog timeout, active high.
  input wire logic i_por, // Power-on detector, active high.
  input wire logic i_bod_warn, // Supply below upper threshold.
  input wire logic i_bod_reset, // Supply below lower threshold.
  input wire logic i_osc_running, // Oscillator is running.
  input wire logic i_flash_init_done, // Flash controller is initialised.
  input wire logic [31:0] i_prot_pattern, // Protection word from flash.
  input wire logic i_boot_loader_override_pin, // Boot loader request pin.
  input wire logic i_pd_req, // Processor enters power-down, pulse.
  input wire logic i_main_osc_sel, // Main oscillator was the clock.
  input wire logic [NIRQ-1:0] i_ext_irq, // External interrupt inputs.
  input wire logic [`SRB_ADDR_W-1:0] i_addr, // Register address.
  input wire logic [31:0] i_wdata, // Register write data.
  input wire logic i_we, // Write strobe.
  input wire logic i_re, // Read strobe.
  output logic [31:0] o_rdata, // Read data, cycle after the strobe.
  output logic o_sys_rst, // Internal reset, active high.
  output logic o_cpu_run, // Processor may execute.
  output logic o_bod_irq, // Brownout request to the interrupt controller.
  output logic o_irq, // Block interrupt, level.
  output logic [1:0] o_vecmap, // Vector source at address zero.
  output logic o_flash_wr_allow, // Flash alteration permitted.
  output logic o_iap_allow, // In-application flash calls permitted.
  output srb_pkg::srb_access_s o_access // Debug and boot loader gating.
);
  srb_pkg::srb_state_s st;
  srb_pkg::srb_state_s next_st;
  logic any_cause;
  logic sync_rst;
  logic [`SRB_ST_W-1:0] set_ev;
  logic [`SRB_CNT_W-1:0] wake_target;
  logic wr_ok;

  initial begin
    if (RST_CNT < 1 || RST_CNT > 8191) begin
      $error("RST_CNT must lie between 1 and 8191.");
    end
    if (NIRQ < 1 || NIRQ > 32) begin
      $error("NIRQ must lie between 1 and 32.");
    end
  end

  // Maps the flash protection word onto a level; other words leave it open.
  function automatic srb_pkg::srb_prot_e decode_prot(input logic [31:0] w);
    case (w)
      `SRB_PAT_L1: decode_prot = srb_pkg::PROT_ONE;
      `SRB_PAT_L2: decode_prot = srb_pkg::PROT_TWO;
      `SRB_PAT_L3: decode_prot = srb_pkg::PROT_THREE;
      default: decode_prot = srb_pkg::PROT_NONE;
    endcase
  endfunction : decode_prot

  // (R1) Merge causes.
  // (R8) Brownout and power-on both hold reset, so the handover is seamless.
  assign any_cause = i_rst | !i_rst_pin_n | i_wdt_timeout | i_por
    | i_bod_reset;

  // (R17) Two-stage release.
  srb_rst_sync #(
    .STAGES(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_arst(any_cause),
    .o_rst(sync_rst)
  );

  // Sticky events; the brownout warning is caught on its rising edge.
  always_comb begin
    set_ev = '0;
    set_ev[`SRB_ST_BODWARN] = i_bod_warn & !st.bod_warn_d;
    set_ev[`SRB_ST_WAKE] = (st.seq == srb_pkg::S_SLEEP)
      & |(i_ext_irq & st.wake_en);
    set_ev[`SRB_ST_BODRST] = i_bod_reset;
    set_ev[`SRB_ST_WDT] = i_wdt_timeout;
    set_ev[`SRB_ST_PIN] = !i_rst_pin_n;
  end

  // (R16) Resume delay depends on which oscillator ran before sleep.
  assign wake_target = i_main_osc_sel ? `SRB_WAKE_MAIN : `SRB_WAKE_IRC;

  // One next-state process for the whole block.
  always_comb begin
    next_st = st;
    next_st.bod_warn_d = i_bod_warn;
    // (R5) Warning level
    // (R6) Readable level
    next_st.bod_lvl = i_bod_warn;
    next_st.rdata = '0;
    // Status clears on written ones; a new event in the same cycle wins.
    if (i_we && i_addr == `SRB_OFF_STATUS) begin
      next_st.status = st.status & ~i_wdata[`SRB_ST_W-1:0];
    end
    next_st.status = next_st.status | set_ev;
    if (i_we && i_addr == `SRB_OFF_MASK) begin
      next_st.mask = i_wdata[`SRB_ST_W-1:0];
    end
    // (R14) Vector source
    if (i_we && i_addr == `SRB_OFF_VECMAP && i_wdata[1:0] != 2'h3) begin
      next_st.vecmap = i_wdata[1:0];
    end
    if (i_we && i_addr == `SRB_OFF_WAKEEN) begin
      next_st.wake_en = i_wdata[NIRQ-1:0];
    end
    if (i_re) begin
      case (i_addr)
        `SRB_OFF_STATUS: next_st.rdata[`SRB_ST_W-1:0] = st.status;
        `SRB_OFF_MASK: next_st.rdata[`SRB_ST_W-1:0] = st.mask;
        `SRB_OFF_BODLVL: next_st.rdata[0] = st.bod_lvl;
        `SRB_OFF_VECMAP: next_st.rdata[1:0] = st.vecmap;
        `SRB_OFF_WAKEEN: next_st.rdata[NIRQ-1:0] = st.wake_en;
        `SRB_OFF_PROT: next_st.rdata[1:0] = st.level;
        default: next_st.rdata = '0;
      endcase
    end
    // Reset sequence and sleep handling.
    case (st.seq)
      // (R2) Wake-up timer
      srb_pkg::S_HOLD: begin
        next_st.cnt = '0;
        if (i_osc_running) begin
          next_st.seq = srb_pkg::S_OSC;
        end
      end
      // (R3) Clock count
      srb_pkg::S_OSC: begin
        next_st.cnt = st.cnt + 1'b1;
        if (!i_osc_running) begin
          next_st.seq = srb_pkg::S_HOLD;
        end else if (st.cnt == RST_CNT[`SRB_CNT_W-1:0] - 1'b1) begin
          next_st.seq = srb_pkg::S_FLASH;
        end
      end
      // (R9) Protection word is read once flash is ready.
      srb_pkg::S_FLASH: begin
        if (i_flash_init_done) begin
          next_st.seq = srb_pkg::S_RUN;
          next_st.level = decode_prot(i_prot_pattern);
          // (R12) Override pin
          next_st.boot_entry = i_boot_loader_override_pin
            && decode_prot(i_prot_pattern) != srb_pkg::PROT_THREE;
        end
      end
      srb_pkg::S_RUN: begin
        if (i_pd_req) begin
          next_st.seq = srb_pkg::S_SLEEP;
        end
      end
      // (R15) Wake sources
      srb_pkg::S_SLEEP: begin
        next_st.cnt = '0;
        if (|(i_ext_irq & st.wake_en)) begin
          next_st.seq = srb_pkg::S_RESUME;
        end
      end
      // (R16) Resume count
      srb_pkg::S_RESUME: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == wake_target - 1'b1) begin
          next_st.seq = srb_pkg::S_RUN;
        end
      end
      default: next_st.seq = srb_pkg::S_HOLD;
    endcase
    // (R4) Defined values while reset holds; vectors back to boot block.
    if (sync_rst) begin
      next_st.seq = srb_pkg::S_HOLD;
      next_st.cnt = '0;
      next_st.vecmap = `SRB_VEC_BOOT;
      next_st.wake_en = '0;
      next_st.mask = '0;
      next_st.level = srb_pkg::PROT_NONE;
      next_st.boot_entry = 1'b0;
    end
  end

  // State register; causes in the status survive the internal reset.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '{seq: srb_pkg::S_HOLD, vecmap: `SRB_VEC_BOOT,
        level: srb_pkg::PROT_NONE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // (R3) Internal reset
  assign o_sys_rst = sync_rst | st.seq == srb_pkg::S_HOLD
    | st.seq == srb_pkg::S_OSC | st.seq == srb_pkg::S_FLASH;
  assign o_cpu_run = st.seq == srb_pkg::S_RUN && !sync_rst;
  assign o_rdata = st.rdata;
  // (R5) Brownout request
  assign o_bod_irq = st.bod_lvl;
  assign o_irq = |(st.status & st.mask);
  assign o_vecmap = st.vecmap;
  // (R7) Flash lock
  assign wr_ok = !o_sys_rst && !i_bod_reset;
  assign o_flash_wr_allow = wr_ok;
  // (R13) Calls stay open at every protection level.
  assign o_iap_allow = wr_ok;

  // Gating derived from the latched level; reset clears it to open until the word is read again.
  always_comb begin
    o_access = '0;
    o_access.boot_entry = st.boot_entry;
    case (st.level)
      srb_pkg::PROT_NONE: begin
        o_access.debug_en = 1'b1;
        o_access.bootldr_en = 1'b1;
      end
      // (R10) Level one
      srb_pkg::PROT_ONE: begin
        o_access.bootldr_en = 1'b1;
        o_access.sector0_lock = 1'b1;
      end
      // (R11) Level two
      srb_pkg::PROT_TWO: begin
        o_access.bootldr_en = 1'b1;
        o_access.full_erase_only = 1'b1;
      end
      // (R12) Level three
      default: o_access = '0;
    endcase
  end

  // Checks share the block clock, and the block reset masks them because
  // every register is forced then and old sampled values mean nothing.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_cause_resets: assert property ( // (R1)
    (i_wdt_timeout || !i_rst_pin_n || i_por) |=> o_sys_rst)
    else $error("Reset cause did not hold internal reset.");
  a_osc_gate: assert property ( // (R3)
    !i_osc_running && st.seq == srb_pkg::S_HOLD |=> o_sys_rst)
    else $error("Reset released without oscillator.");
  a_flash_gate: assert property ( // (R3)
    $fell(o_sys_rst) |-> $past(i_flash_init_done))
    else $error("Reset released before flash was ready.");
  a_vec_boot: assert property ( // (R4)
    $fell(o_sys_rst) |-> o_vecmap == `SRB_VEC_BOOT)
    else $error("Vectors not on boot block at release.");
  a_bod_irq: assert property ( // (R5)
    $rose(i_bod_warn) |=> o_bod_irq && st.status[`SRB_ST_BODWARN])
    else $error("Brownout warning not raised.");
  a_bod_flash: assert property ( // (R7)
    i_bod_reset |-> !o_flash_wr_allow ##1 o_sys_rst)
    else $error("Brownout reset left flash writable.");
  a_lvl3_lock: assert property ( // (R12)
    st.level == srb_pkg::PROT_THREE |-> !o_access.debug_en
      && !o_access.bootldr_en && !o_access.boot_entry)
    else $error("Level three left an access path open.");
  a_wake_irc: assert property ( // (R16)
    st.seq == srb_pkg::S_SLEEP && |(i_ext_irq & st.wake_en) && !sync_rst
      && !i_main_osc_sel ##1 !i_main_osc_sel[*4] ##0 !sync_rst
      |=> o_cpu_run)
    else $error("Wake did not resume after four cycles.");
  a_wake_delay: assert property ( // (R15)
    st.seq == srb_pkg::S_SLEEP && !sync_rst |=> !o_cpu_run)
    else $error("Processor ran straight out of sleep.");
  a_irq_mask: assert property ( // (R6)
    st.mask == '0 |-> !o_irq)
    else $error("Masked status raised the interrupt.");

  // (R17) Two-edge release.
  a_release_sync: assert property ( // (R17)
    $fell(any_cause) |-> o_sys_rst ##1 o_sys_rst)
    else $error("Reset left before two synchroniser edges.");
  // (R2) Timer restart.
  a_timer_start: assert property ( // (R2)
    sync_rst |=> st.seq == srb_pkg::S_HOLD && st.cnt == '0)
    else $error("Reset did not restart the wake-up timer.");
  // (R3) Pin holds reset.
  a_pin_hold: assert property ( // (R3)
    !i_rst_pin_n |-> o_sys_rst && !o_cpu_run)
    else $error("Reset pin low but processor running.");
  // (R3) Count bound.
  a_count_bound: assert property ( // (R3)
    st.seq == srb_pkg::S_OSC |-> o_sys_rst && st.cnt < RST_CNT)
    else $error("Clock count ran past its end.");
  // (R8) Handover holds reset.
  a_bod_handover: assert property ( // (R8)
    i_bod_reset || i_por |-> o_sys_rst && !o_flash_wr_allow)
    else $error("Supply fault left reset or flash writes open.");
  // (R6) Level read back.
  a_status_read: assert property ( // (R6)
    i_re && i_addr == `SRB_OFF_BODLVL |=> o_rdata[0] == $past(o_bod_irq))
    else $error("Brownout level read back wrong.");
  // (R5) Warning stays sticky.
  a_bod_sticky: assert property ( // (R5)
    st.status[`SRB_ST_BODWARN] && !(i_we && i_addr == `SRB_OFF_STATUS)
      |=> st.status[`SRB_ST_BODWARN])
    else $error("Brownout status bit lost without a clear.");
  // (R14) Vector write lands.
  a_vec_select: assert property ( // (R14)
    i_we && i_addr == `SRB_OFF_VECMAP && i_wdata[1:0] != 2'h3 && !sync_rst
      |=> o_vecmap == $past(i_wdata[1:0]))
    else $error("Vector source write did not land.");
  // (R14) Reserved code ignored.
  a_vec_reserved: assert property ( // (R14)
    i_we && i_addr == `SRB_OFF_VECMAP && i_wdata[1:0] == 2'h3 && !sync_rst
      |=> $stable(o_vecmap))
    else $error("Reserved vector code was taken.");
  // (R10) Level one gating.
  a_lvl1_gate: assert property ( // (R10)
    st.level == srb_pkg::PROT_ONE |-> !o_access.debug_en
      && o_access.bootldr_en && o_access.sector0_lock)
    else $error("Level one gating wrong.");
  // (R11) Level two gating.
  a_lvl2_gate: assert property ( // (R11)
    st.level == srb_pkg::PROT_TWO |-> !o_access.debug_en
      && o_access.bootldr_en && o_access.full_erase_only)
    else $error("Level two gating wrong.");
  // (R13) Calls stay open.
  a_iap_level: assert property ( // (R13)
    !o_sys_rst && !i_bod_reset |-> o_iap_allow && o_flash_wr_allow)
    else $error("Flash calls closed outside reset.");
  // (R16) No early resume.
  a_resume_hold: assert property ( // (R16)
    st.seq == srb_pkg::S_RESUME && st.cnt != wake_target - 1'b1
      |=> !o_cpu_run)
    else $error("Processor resumed before the count ended.");
endmodule : srb_top
`default_nettype wire

// ===== rtl/srb_consts.svh
// Offsets, field positions, reset values and counts of the reset block.
`ifndef SRB_CONSTS_SVH
`define SRB_CONSTS_SVH
`define SRB_ADDR_W 8
`define SRB_OFF_STATUS 8'h00
`define SRB_OFF_MASK 8'h04
`define SRB_OFF_BODLVL 8'h08
`define SRB_OFF_VECMAP 8'h0C
`define SRB_OFF_WAKEEN 8'h10
`define SRB_OFF_PROT 8'h14
`define SRB_ST_W 5
`define SRB_ST_BODWARN 0
`define SRB_ST_WAKE 1
`define SRB_ST_BODRST 2
`define SRB_ST_WDT 3
`define SRB_ST_PIN 4
`define SRB_VEC_BOOT 2'h0
`define SRB_VEC_SRAM 2'h1
`define SRB_VEC_EXT 2'h2
`define SRB_NIRQ 4
`define SRB_CNT_W 13
`define SRB_RST_CNT 1024
`define SRB_WAKE_IRC 13'h0004
`define SRB_WAKE_MAIN 13'h1000
`define SRB_PAT_L1 32'h12345678
`define SRB_PAT_L2 32'h87654321
`define SRB_PAT_L3 32'h43218765
`endif

// ===== rtl/srb_pkg.sv
// Types shared by the reset and brownout control block.
`include "srb_consts.svh"
package srb_pkg;
  typedef enum logic [5:0] {
    S_HOLD = 6'h01,
    S_OSC = 6'h02,
    S_FLASH = 6'h04,
    S_RUN = 6'h08,
    S_SLEEP = 6'h10,
    S_RESUME = 6'h20
  } srb_seq_e;
  typedef enum logic [1:0] {
    PROT_NONE = 2'h0,
    PROT_ONE = 2'h1,
    PROT_TWO = 2'h2,
    PROT_THREE = 2'h3
  } srb_prot_e;
  typedef struct packed {
    logic bootldr_en;
    logic sector0_lock;
    logic full_erase_only;
    logic debug_en;
    logic boot_entry;
  } srb_access_s;
  typedef struct packed {
    srb_seq_e seq;
    logic [`SRB_CNT_W-1:0] cnt;
    logic [`SRB_ST_W-1:0] status;
    logic [`SRB_ST_W-1:0] mask;
    logic [1:0] vecmap;
    logic [`SRB_NIRQ-1:0] wake_en;
    srb_prot_e level;
    logic boot_entry;
    logic bod_lvl;
    logic bod_warn_d;
    logic [31:0] rdata;
  } srb_state_s;
endpackage : srb_pkg

// ===== rtl/srb_rst_sync.sv
// Reset synchroniser: asynchronous assertion, clocked release.
`timescale 1ns/10ps
`default_nettype none
module srb_rst_sync #(
  parameter int STAGES = 2
) (
  input wire logic i_clk, // Block clock.
  input wire logic i_arst, // Combined reset causes, active high.
  output logic o_rst // Reset with synchronous release.
);
  logic [STAGES-1:0] chain;

  initial begin
    if (STAGES < 2) begin
      $error("STAGES must be at least two.");
    end
  end

  // Ones shift out only on clock edges, so release never races the clock.
  always_ff @(posedge i_clk or posedge i_arst) begin
    if (i_arst) begin
      chain <= '1;
    end else begin
      chain <= {chain[STAGES-2:0], 1'b0};
    end
  end

  assign o_rst = chain[STAGES-1];
endmodule : srb_rst_sync
`default_nettype wire

// ===== testbench/srb_far_model.sv
// Far-side model: oscillator and flash controller start-up behaviour.
`timescale 1ns/10ps
`default_nettype none
module srb_far_model (
  input wire logic i_clk, // Block clock.
  input wire logic i_sys_rst, // Internal reset from the block.
  input wire logic i_slow, // Stretch flash start-up.
  output logic o_osc_running, // Oscillator is running.
  output logic o_flash_init_done // Flash controller is ready.
);
  logic [7:0] cnt = 8'h00;
  logic prev = 1'b0;
  // Oscillator start-up.
  // The oscillator restarts with each reset and needs four cycles to run,
  // so the block has to wait for it before counting.
  assign o_osc_running = (cnt >= 8'h04);
  // Flash restarts init.
  // Flash re-initialises on each new reset, so the block must wait for it.
  always_ff @(posedge i_clk) begin
    prev <= i_sys_rst;
    if (i_sys_rst && !prev) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hFF) begin
      cnt <= cnt + 8'h01;
    end
  end
  assign o_flash_init_done = (cnt >= (i_slow ? 8'h3C : 8'h03));
endmodule : srb_far_model
`default_nettype wire

// ===== testbench/srb_top_tb.sv
// Self-checking testbench of the reset and brownout control block.
`timescale 1ns/10ps
`default_nettype none
`include "srb_consts.svh"
module srb_top_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] cause = 4'h0;
  logic i_bod_warn = 1'b0, i_osc_running, i_flash_init_done, slow = 1'b0;
  logic [31:0] i_prot_pattern = 32'h00000000;
  logic i_bl_pin = 1'b1, i_pd_req = 1'b0, i_main_osc_sel = 1'b0;
  logic [3:0] i_ext_irq = 4'h0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h00000000, o_rdata;
  logic i_we = 1'b0, i_re = 1'b0;
  logic o_sys_rst, o_cpu_run, o_bod_irq, o_irq, o_fwa, o_iap;
  logic [1:0] o_vecmap;
  srb_pkg::srb_access_s o_access;
  int n_fail = 0, compares = 0, cyc = 0, i;
  logic [31:0] pat [4] = '{32'h0, `SRB_PAT_L1, `SRB_PAT_L2, `SRB_PAT_L3};
  logic [4:0] acc [4] = '{5'h13, 5'h19, 5'h15, 5'h00};

  always #12.5 i_clk = ~i_clk;

  srb_top #(.RST_CNT(8), .NIRQ(4)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_rst_pin_n(~cause[0]), .i_wdt_timeout(cause[1]), .i_por(cause[2]),
    .i_bod_warn(i_bod_warn), .i_bod_reset(cause[3]),
    .i_osc_running(i_osc_running), .i_flash_init_done(i_flash_init_done),
    .i_prot_pattern(i_prot_pattern), .i_boot_loader_override_pin(i_bl_pin),
    .i_pd_req(i_pd_req), .i_main_osc_sel(i_main_osc_sel),
    .i_ext_irq(i_ext_irq), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
    .i_re(i_re), .o_rdata(o_rdata), .o_sys_rst(o_sys_rst),
    .o_cpu_run(o_cpu_run), .o_bod_irq(o_bod_irq), .o_irq(o_irq),
    .o_vecmap(o_vecmap), .o_flash_wr_allow(o_fwa), .o_iap_allow(o_iap),
    .o_access(o_access));

  srb_far_model u_far (.i_clk(i_clk), .i_sys_rst(o_sys_rst), .i_slow(slow),
    .o_osc_running(i_osc_running), .o_flash_init_done(i_flash_init_done));

  task automatic tally_and_finish;
    $display("Compares %0d, errors %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_we <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_re <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask : rd

  // Bounded wait for the processor to be let run.
  task automatic wait_run;
    int n;
    n = 0;
    while (o_cpu_run !== 1'b1 && n < 300) begin
      @(posedge i_clk);
      #1 n++;
    end
    chk({o_sys_rst, o_cpu_run, o_fwa, o_iap}, 4'h7);
  endtask : wait_run

  // Pulse one reset cause; reset must assert in the same cycle.
  task automatic pulse(input logic [3:0] c);
    @(posedge i_clk);
    cause <= c;
    #1 chk({o_sys_rst, o_cpu_run}, 2'h2);
    @(posedge i_clk);
    cause <= 4'h0;
    @(posedge i_clk);
    #1 chk(o_sys_rst, 1'b1);
  endtask : pulse

  // Sleep, ignore a disabled source, then count resume cycles.
  task automatic sleep_wake(input logic sel, input int lo, input int hi);
    int n;
    i_main_osc_sel <= sel;
    @(posedge i_clk);
    i_pd_req <= 1'b1;
    @(posedge i_clk);
    i_pd_req <= 1'b0;
    i_ext_irq <= 4'h2;
    repeat (10) @(posedge i_clk);
    #1 chk(o_cpu_run, 1'b0);
    @(posedge i_clk);
    i_ext_irq <= 4'h1;
    n = 0;
    @(posedge i_clk);
    while (o_cpu_run !== 1'b1 && n < 5000) begin
      @(posedge i_clk);
      #1 n++;
    end
    chk(n >= lo && n <= hi, 1'b1);
    i_ext_irq <= 4'h0;
  endtask : sleep_wake

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk({o_cpu_run, o_vecmap, o_irq}, 4'h0);
    wait_run();
    chk(o_vecmap, `SRB_VEC_BOOT);
    // Each cause alone must reset and restart the whole sequence.
    for (i = 0; i < 4; i++) begin
      pulse(4'h1 << i);
      wait_run();
    end
    rd(`SRB_OFF_STATUS, 32'h1C);
    wr(`SRB_OFF_STATUS, 32'h1F);
    rd(`SRB_OFF_STATUS, 32'h00);
    rd(8'hF0, 32'h0);
    // Brownout reset hands over to power-on reset without a gap.
    @(posedge i_clk);
    cause <= 4'hC;
    #1 chk(o_fwa, 1'b0);
    @(posedge i_clk);
    cause <= 4'h4;
    repeat (30) @(posedge i_clk);
    #1 chk(o_sys_rst, 1'b1);
    cause <= 4'h0;
    wait_run();
    // Slow flash start-up must keep reset asserted.
    slow <= 1'b1;
    pulse(4'h2);
    repeat (30) @(posedge i_clk);
    #1 chk(o_sys_rst, 1'b1);
    wait_run();
    slow <= 1'b0;
    // Brownout warning: level to controller, status, masked interrupt.
    i_bod_warn <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk({o_bod_irq, o_irq}, 2'h2);
    rd(`SRB_OFF_BODLVL, 32'h1);
    wr(`SRB_OFF_MASK, 32'h1);
    #1 chk(o_irq, 1'b1);
    i_bod_warn <= 1'b0;
    wr(`SRB_OFF_STATUS, 32'h1);
    #1 chk(o_irq, 1'b0);
    rd(`SRB_OFF_BODLVL, 32'h0);
    // Vector source selection; the unused code is ignored.
    wr(`SRB_OFF_VECMAP, 32'h1);
    rd(`SRB_OFF_VECMAP, 32'h1);
    wr(`SRB_OFF_VECMAP, 32'h2);
    wr(`SRB_OFF_VECMAP, 32'h3);
    #1 chk(o_vecmap, `SRB_VEC_EXT);
    // Protection levels, each taken at the end of a reset.
    for (i = 0; i < 4; i++) begin
      i_prot_pattern <= pat[i];
      pulse(4'h2);
      wait_run();
      chk(o_vecmap, `SRB_VEC_BOOT);
      rd(`SRB_OFF_PROT, i);
      chk(o_access, acc[i]);
    end
    wr(`SRB_OFF_STATUS, 32'h1F);
    wr(`SRB_OFF_WAKEEN, 32'h1);
    sleep_wake(1'b0, 4, 7);
    sleep_wake(1'b1, 4096, 4099);
    rd(`SRB_OFF_STATUS, 32'h2);
    tally_and_finish();
  end
endmodule : srb_top_tb
`default_nettype wire
